// file: shared/io_pkg.sv
// Package with constants and carrier types for the I/O element block
package io_pkg;

    // Block sizing
    localparam int NUM_ELEM = 6;         // Elements in a column block
    localparam int ROW_ELEM = 4;         // Elements usable in a row block
    localparam int BLK_LINES = 4;        // Lines per shared control group
    localparam int IO_CLK_LINES = 8;     // Dedicated low-skew clock lines
    localparam int CTRL_LINE_COUNT = 16; // Shared control lines per block
    localparam int ROW_LINE_COUNT = 28;  // Per-element lines, row block
    localparam int COL_LINE_COUNT = 42;  // Per-element lines, column block
    localparam int SEL_W = 4;            // Width of a source select code
    localparam int CAP_W = 2 * NUM_ELEM; // Captured bits leaving the block

    // Clock period in ns at the 20 MHz system rate
    localparam int CLK_PERIOD_NS = 50;

    // Source select codes shared by every control of an element
    localparam logic [3:0] SRC_BLK0 = 4'h0;  // Shared block line 0..3
    localparam logic [3:0] SRC_ELEM = 4'h4;  // Per-element I/O line
    localparam logic [3:0] SRC_ARRAY = 4'h5; // Direct logic array line
    localparam logic [3:0] SRC_ONE = 4'h6;   // Tied active
    localparam logic [3:0] SRC_ZERO = 4'h7;  // Tied inactive
    localparam logic [3:0] SRC_IOCLK0 = 4'h8; // Dedicated clock 0..7

    // Async clear or preset level of each element, bit per element
    localparam logic [5:0] ASYNC_SET_MASK = 6'h00;

    // Shared high-fanout control lines of one block
    typedef struct packed {
        logic [3:0] oe;  // Output enables
        logic [3:0] ce;  // Clock enables
        logic [3:0] clk; // Clock enable pulses
        logic [3:0] clr; // Clears
    } blk_ctrl_s;

    // Per-element data and control lines
    typedef struct packed {
        logic dout_a; // First output bit
        logic dout_b; // Second output bit
        logic oe;     // Output enable
        logic ce_in;  // Input clock enable
        logic ce_out; // Output clock enable
        logic clk;    // Clock enable pulse
        logic clr;    // Clear
    } elem_line_s;

    // Per-element configuration
    typedef struct packed {
        logic [3:0] oe_src;     // Output enable source
        logic [3:0] cein_src;   // Input clock enable source
        logic [3:0] ceout_src;  // Output clock enable source
        logic [3:0] aclr_src;   // Async clear or preset source
        logic [3:0] sclr_src;   // Sync clear or preset source
        logic [3:0] clkin_src;  // Input clock source
        logic [3:0] clkout_src; // Output and OE clock source
        logic data_array;       // Output data from logic array
        logic ddr_in;           // Double-rate capture
        logic ddr_out;          // Double-rate drive
        logic oe_reg_en;        // Registered output enable
        logic oe_neg_en;        // Falling-edge OE stage in use
        logic sclr_set;         // Sync event presets instead of clears
    } elem_cfg_s;

    // Resolved controls handed to one element cell
    typedef struct packed {
        logic enable;    // Element exists in this block
        logic clkin_en;  // Input clock pulse
        logic cein;      // Input clock enable
        logic clkout_en; // Output clock pulse
        logic ceout;     // Output clock enable
        logic aclr;      // Async clear or preset
        logic sclr;      // Sync clear or preset
        logic oe_raw;    // Unregistered output enable
        logic dout_a;    // First output bit
        logic dout_b;    // Second output bit
        logic ddr_in;    // Double-rate capture
        logic ddr_out;   // Double-rate drive
        logic oe_reg_en; // Registered output enable
        logic oe_neg_en; // Falling-edge OE stage
        logic sclr_set;  // Sync preset level
    } cell_ctrl_s;

endpackage

// file: src/io_element_cell.sv
// One bidirectional I/O element: capture, drive and enable registers
`timescale 1ns/1ps

module io_element_cell #(
    parameter logic ASYNC_SET = 1'b0 // Level forced by async clear
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Resolved controls
    input io_pkg::cell_ctrl_s ctrl_in,
    // Pin side
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_out,
    // Captured pair, first bit high
    output logic [1:0] cap_out
);

    // Rising-edge state
    typedef struct packed {
        logic in_a;   // Rising-edge capture
        logic in_lat; // Falling bit realigned
        logic out_a;  // First output bit
        logic out_b;  // Second output bit
        logic oe_q;   // Registered output enable
    } pos_s;

    // Falling-edge state
    typedef struct packed {
        logic in_b;   // Falling-edge capture
        logic oe_neg; // Falling-edge output enable
    } neg_s;

    pos_s pos_reg;
    pos_s pos_next;
    neg_s neg_reg;
    logic rst_n; // Board reset or selected async clear

    // Async clear acts at once, without a clock edge
    assign rst_n = arst_n_in & ~ctrl_in.aclr;

    // Next rising-edge state
    always_comb begin
        pos_next = pos_reg;
        // Input side, own clock and enable
        if (ctrl_in.enable && ctrl_in.clkin_en && ctrl_in.cein) begin
            if (ctrl_in.sclr) begin
                pos_next.in_a = ctrl_in.sclr_set;
                pos_next.in_lat = ctrl_in.sclr_set;
            end else begin
                pos_next.in_a = pin_in;
                // Held falling bit joins the rising one
                pos_next.in_lat = ctrl_in.ddr_in ? neg_reg.in_b : pin_in;
            end
        end
        // Output and OE share one clock and enable
        if (ctrl_in.enable && ctrl_in.clkout_en && ctrl_in.ceout) begin
            if (ctrl_in.sclr) begin
                pos_next.out_a = ctrl_in.sclr_set;
                pos_next.out_b = ctrl_in.sclr_set;
                pos_next.oe_q = 1'b0;
            end else begin
                pos_next.out_a = ctrl_in.dout_a;
                pos_next.out_b = ctrl_in.dout_b;
                pos_next.oe_q = ctrl_in.oe_raw;
            end
        end
    end

    // Rising-edge registers
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pos_reg <= '{default: ASYNC_SET};
        end else begin
            pos_reg <= pos_next;
        end
    end

    // Falling-edge capture and OE delay stage
    always_ff @(negedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            neg_reg <= '{default: ASYNC_SET};
        end else if (ctrl_in.enable) begin
            if (ctrl_in.cein) begin
                neg_reg.in_b <= pin_in;
            end
            neg_reg.oe_neg <= pos_reg.oe_q;
        end
    end

    // Pin drive: first bit while clock high, second while low
    assign pin_out = (ctrl_in.ddr_out && !clk_in) ? pos_reg.out_b : pos_reg.out_a;

    // Registered or direct enable; falling stage delays turn-on
    always_comb begin
        if (!ctrl_in.enable) begin
            pin_oe_out = 1'b0;
        end else if (!ctrl_in.oe_reg_en) begin
            pin_oe_out = ctrl_in.oe_raw;
        end else if (ctrl_in.oe_neg_en) begin
            pin_oe_out = pos_reg.oe_q & neg_reg.oe_neg;
        end else begin
            pin_oe_out = pos_reg.oe_q;
        end
    end

    // Both bits presented on the same rising edge
    assign cap_out = ctrl_in.ddr_in ? {pos_reg.in_a, pos_reg.in_lat}
                                    : {pos_reg.in_a, pos_reg.in_a};

endmodule // io_element_cell

// file: src/io_element_block.sv
// I/O block: control selection, routing and six element cells
//
// Functional notes
// - Six registers plus latch per element
// - Double-rate capture and drive use both registers
// - Registered output enable, or direct enable
// - One OE register clocks on falling edge
// - Each element selects its own control sources
// - Input register has own clock and enable
// - Output and OE registers share clock, enable
// - Row block four elements, column block six
// - Row drives all nets; column only column
// - Sixteen shared control lines per block
// - Row block takes 28 per-element lines
// - Column block takes 42 per-element lines
// - Captured input routed onto I/O interconnect
// - Controls and data also from logic array
// - Eight dedicated I/O clock lines available
// - Latch aligns both captured bits to edge
// - Pin shows first bit high, second low
// - Falling OE stage holds driver off first
// - Output registers hold when enable low
`timescale 1ns/1ps

module io_element_block (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // Block shape: high for a row block, low for a column block
    input wire logic ROW_BLOCK_IN,
    // Shared high-fanout control lines
    input io_pkg::blk_ctrl_s BLK_CTRL_IN,
    // Dedicated I/O clock enable pulses
    input wire logic [io_pkg::IO_CLK_LINES-1:0] IO_CLK_IN,
    // Per-element lines from the I/O interconnect
    input io_pkg::elem_line_s [io_pkg::NUM_ELEM-1:0] ELEM_LINES_IN,
    // Per-element lines straight from the logic array
    input io_pkg::elem_line_s [io_pkg::NUM_ELEM-1:0] ARRAY_LINES_IN,
    // Per-element configuration
    input io_pkg::elem_cfg_s [io_pkg::NUM_ELEM-1:0] ELEM_CFG_IN,
    // Package pins
    input wire logic [io_pkg::NUM_ELEM-1:0] PIN_IN,
    output logic [io_pkg::NUM_ELEM-1:0] PIN_OUT,
    output logic [io_pkg::NUM_ELEM-1:0] PIN_OE_OUT,
    // Captured data onto the interconnect
    output logic [io_pkg::CAP_W-1:0] COL_DATA_OUT,
    output logic [io_pkg::CAP_W-1:0] ROW_DATA_OUT,
    output logic [io_pkg::CAP_W-1:0] DIRECT_DATA_OUT
);

    // Block-level state: registered interconnect drivers
    typedef struct packed {
        logic [io_pkg::CAP_W-1:0] col;    // Column interconnect
        logic [io_pkg::CAP_W-1:0] row;    // Row interconnect
        logic [io_pkg::CAP_W-1:0] direct; // Direct link
    } blk_state_s;

    blk_state_s state_reg;
    blk_state_s state_next;

    // Resolved controls per element
    io_pkg::cell_ctrl_s [io_pkg::NUM_ELEM-1:0] cell_ctrl;
    // Captured pairs from all elements
    logic [io_pkg::CAP_W-1:0] cap_all;
    // Elements that exist in this block shape
    logic [io_pkg::NUM_ELEM-1:0] elem_en;

    // Pick one control level from its configured source
    function automatic logic pick_src(
        input logic [3:0] sel,
        input logic [3:0] blk,
        input logic elem,
        input logic arr,
        input logic [7:0] ioclk
    );
        logic res;
        res = 1'b0;
        case (sel)
            4'h0, 4'h1, 4'h2, 4'h3: res = blk[sel[1:0]];
            io_pkg::SRC_ELEM: res = elem;
            io_pkg::SRC_ARRAY: res = arr;
            io_pkg::SRC_ONE: res = 1'b1;
            io_pkg::SRC_ZERO: res = 1'b0;
            default: res = ioclk[sel[2:0]];
        endcase
        return res;
    endfunction

    // Build the resolved control set for one element
    function automatic io_pkg::cell_ctrl_s make_ctrl(
        input io_pkg::elem_cfg_s cfg,
        input io_pkg::elem_line_s ln,
        input io_pkg::elem_line_s arr,
        input io_pkg::blk_ctrl_s blk,
        input logic [7:0] ioclk,
        input logic en
    );
        io_pkg::cell_ctrl_s c;
        c = '0;
        c.enable = en;
        // Clocks may come from block, element, array or I/O clocks
        c.clkin_en = pick_src(cfg.clkin_src, blk.clk, ln.clk, arr.clk, ioclk);
        c.clkout_en = pick_src(cfg.clkout_src, blk.clk, ln.clk, arr.clk, ioclk);
        // Enables and clears never see the dedicated clocks
        c.cein = pick_src(cfg.cein_src, blk.ce, ln.ce_in, arr.ce_in, 8'h00);
        c.ceout = pick_src(cfg.ceout_src, blk.ce, ln.ce_out, arr.ce_out, 8'h00);
        c.aclr = pick_src(cfg.aclr_src, blk.clr, ln.clr, arr.clr, 8'h00);
        c.sclr = pick_src(cfg.sclr_src, blk.clr, ln.clr, arr.clr, 8'h00);
        c.oe_raw = pick_src(cfg.oe_src, blk.oe, ln.oe, arr.oe, 8'h00);
        // Output data over the I/O lines or the slower array path
        c.dout_a = cfg.data_array ? arr.dout_a : ln.dout_a;
        c.dout_b = cfg.data_array ? arr.dout_b : ln.dout_b;
        // Mode bits pass through
        c.ddr_in = cfg.ddr_in;
        c.ddr_out = cfg.ddr_out;
        c.oe_reg_en = cfg.oe_reg_en;
        c.oe_neg_en = cfg.oe_neg_en;
        c.sclr_set = cfg.sclr_set;
        return c;
    endfunction

    // One cell per element position
    genvar gi;
    generate
        for (gi = 0; gi < io_pkg::NUM_ELEM; gi++) begin : g_elem
            // Row block leaves the upper two positions empty
            assign elem_en[gi] = !(ROW_BLOCK_IN && (gi >= io_pkg::ROW_ELEM));

            // Resolve this element's sources
            assign cell_ctrl[gi] = make_ctrl(ELEM_CFG_IN[gi], ELEM_LINES_IN[gi],
                                             ARRAY_LINES_IN[gi], BLK_CTRL_IN,
                                             IO_CLK_IN, elem_en[gi]);

            // Element registers
            io_element_cell #(
                .ASYNC_SET(io_pkg::ASYNC_SET_MASK[gi])
            ) u_cell (
                .clk_in(CLK_IN),
                .arst_n_in(ARST_N_IN),
                .ctrl_in(cell_ctrl[gi]),
                .pin_in(PIN_IN[gi]),
                .pin_out(PIN_OUT[gi]),
                .pin_oe_out(PIN_OE_OUT[gi]),
                .cap_out(cap_all[2*gi+1 -: 2])
            );
        end
    endgenerate

    // Next interconnect values from captured data
    always_comb begin
        state_next = state_reg;
        // Column interconnect is driven by either block shape
        state_next.col = cap_all;
        if (ROW_BLOCK_IN) begin
            // Row block also drives row and direct link
            state_next.row = cap_all;
            state_next.direct = cap_all;
        end else begin
            // Column block keeps off row and direct link
            state_next.row = '0;
            state_next.direct = '0;
        end
    end

    // Interconnect drivers
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Registered outputs
    assign COL_DATA_OUT = state_reg.col;
    assign ROW_DATA_OUT = state_reg.row;
    assign DIRECT_DATA_OUT = state_reg.direct;

endmodule // io_element_block

// file: verif/io_block_checker.sv
// Port checker for the I/O element block
`timescale 1ns/1ps
module io_block_checker (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // Watched inputs
    input wire logic ROW_BLOCK_IN,
    input wire logic [io_pkg::IO_CLK_LINES-1:0] IO_CLK_IN,
    input io_pkg::elem_line_s [io_pkg::NUM_ELEM-1:0] ELEM_LINES_IN,
    input io_pkg::elem_cfg_s [io_pkg::NUM_ELEM-1:0] ELEM_CFG_IN,
    input wire logic [io_pkg::NUM_ELEM-1:0] PIN_IN,
    // Watched outputs
    input wire logic [io_pkg::NUM_ELEM-1:0] PIN_OUT,
    input wire logic [io_pkg::NUM_ELEM-1:0] PIN_OE_OUT,
    input wire logic [io_pkg::CAP_W-1:0] COL_DATA_OUT,
    input wire logic [io_pkg::CAP_W-1:0] ROW_DATA_OUT,
    input wire logic [io_pkg::CAP_W-1:0] DIRECT_DATA_OUT
);
    logic sdr0; // Element 0 plain drive
    logic ddr1; // Element 1 double-rate drive
    logic neg2; // Element 2 falling-edge enable
    logic cap3; // Element 3 double-rate capture
    logic a1_q; // First bit element 1 loaded
    logic oe2_q; // Element 2 enable before last rise
    logic live_q; // Last rise was a real load
    logic run_q; // Reset already off at the last rise
    assign sdr0 = ELEM_CFG_IN[0].clkout_src == io_pkg::SRC_ONE && !ELEM_CFG_IN[0].ddr_out;
    assign ddr1 = ELEM_CFG_IN[1].ddr_out && ELEM_CFG_IN[1].clkout_src == io_pkg::SRC_IOCLK0;
    assign neg2 = ELEM_CFG_IN[2].oe_neg_en && ELEM_CFG_IN[2].oe_reg_en;
    assign cap3 = ELEM_CFG_IN[3].ddr_in && ELEM_CFG_IN[3].clkin_src == io_pkg::SRC_ONE;
    // Shadow of what the rising edge loaded
    always_ff @(posedge CLK_IN) begin
        a1_q <= ELEM_LINES_IN[1].dout_a;
        oe2_q <= PIN_OE_OUT[2];
        live_q <= ARST_N_IN && IO_CLK_IN[0];
        run_q <= ARST_N_IN;
    end
    // Enable requested while the driver is off
    sequence oe_request;
        neg2 && ELEM_LINES_IN[2].oe && !PIN_OE_OUT[2];
    endsequence
    default clocking cb @(posedge CLK_IN); endclocking
    // Release edge skipped: registers are still held in reset there
    default disable iff (!ARST_N_IN || !run_q);
    a_row_oe_off: assert property (
        ROW_BLOCK_IN && $past(ROW_BLOCK_IN) |-> PIN_OE_OUT[5:4] == 2'h0)
        else $error("row block enables a missing element");
    a_col_nets_off: assert property (
        !ROW_BLOCK_IN && !$past(ROW_BLOCK_IN) |-> (ROW_DATA_OUT | DIRECT_DATA_OUT) == '0)
        else $error("column block drives row or direct nets");
    a_direct_oe: assert property (
        !ELEM_CFG_IN[0].oe_reg_en |-> PIN_OE_OUT[0] == ELEM_LINES_IN[0].oe)
        else $error("direct enable does not follow its source");
    a_hold_out: assert property (sdr0 && !ELEM_LINES_IN[0].ce_out |=> $stable(PIN_OUT[0]))
        else $error("output changed with clock enable low");
    a_sdr_load: assert property (
        sdr0 && ELEM_LINES_IN[0].ce_out |=> PIN_OUT[0] == $past(ELEM_LINES_IN[0].dout_a))
        else $error("output register did not load");
    a_ddr_low: assert property (
        ddr1 && IO_CLK_IN[0] |=> PIN_OUT[1] == $past(ELEM_LINES_IN[1].dout_b))
        else $error("second bit missing in low phase");
    a_ddr_high: assert property (@(negedge CLK_IN) disable iff (!ARST_N_IN || !run_q)
        ddr1 && live_q |-> PIN_OUT[1] == a1_q)
        else $error("first bit missing in high phase");
    a_oe_neg_off: assert property (@(negedge CLK_IN) disable iff (!ARST_N_IN || !run_q)
        neg2 && live_q && !oe2_q |-> !PIN_OE_OUT[2])
        else $error("driver enabled before falling edge");
    a_oe_neg_on: assert property (oe_request |=> PIN_OE_OUT[2])
        else $error("driver not enabled after falling edge");
    a_cap_pair: assert property (cap3 |=> ##1 COL_DATA_OUT[7] == $past(PIN_IN[3], 2))
        else $error("captured first bit wrong");
endmodule // io_block_checker

bind io_element_block io_block_checker io_block_checker_i (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN),
    .ROW_BLOCK_IN(ROW_BLOCK_IN), .IO_CLK_IN(IO_CLK_IN), .ELEM_LINES_IN(ELEM_LINES_IN),
    .ELEM_CFG_IN(ELEM_CFG_IN), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT),
    .COL_DATA_OUT(COL_DATA_OUT), .ROW_DATA_OUT(ROW_DATA_OUT), .DIRECT_DATA_OUT(DIRECT_DATA_OUT));

// file: verif/fabric_model.sv
// Logic array model: dedicated clock pulses and array lines
`timescale 1ns/1ps
module fabric_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Toward the I/O block
    output logic [io_pkg::IO_CLK_LINES-1:0] io_clk_out,
    output io_pkg::elem_line_s [io_pkg::NUM_ELEM-1:0] array_lines_out
);
    logic [41:0] pattern_reg; // Array lines, new every cycle
    // Clock pulses every cycle once out of reset
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            io_clk_out <= 8'h00;
            pattern_reg <= 42'h2AA_AAAA_AAAA;
        end else begin
            io_clk_out <= 8'hFF;
            pattern_reg <= ~pattern_reg;
        end
    end
    assign array_lines_out = pattern_reg;
endmodule // fabric_model

// file: verif/tb_io_element_block.sv
// Testbench for the I/O element block
`timescale 1ns/1ps
module tb_io_element_block;
    localparam io_pkg::elem_cfg_s BASE = '{oe_src: io_pkg::SRC_ZERO, cein_src: io_pkg::SRC_ONE,
        ceout_src: io_pkg::SRC_ONE, aclr_src: io_pkg::SRC_ZERO, sclr_src: io_pkg::SRC_ZERO,
        clkin_src: io_pkg::SRC_ONE, clkout_src: io_pkg::SRC_ONE, default: 1'b0};
    // Rows: dout, ce_out, oe, expected pin, expected enable
    logic [4:0] rows [5] = '{5'h1F, 5'h02, 5'h0D, 5'h15, 5'h1A};
    logic clk; // System clock
    logic arst_n; // Async reset
    logic row_blk; // Block shape
    io_pkg::blk_ctrl_s blk_ctrl; // Shared lines
    logic [7:0] io_clk; // Dedicated clocks
    io_pkg::elem_line_s [5:0] lines; // Element lines
    io_pkg::elem_line_s [5:0] arr_lines; // Array lines
    io_pkg::elem_cfg_s [5:0] cfg; // Element setup
    logic [5:0] pin_in; // Pin levels
    logic [5:0] pin_out; // Pin drive
    logic [5:0] pin_oe; // Pin enable
    logic [11:0] col_data; // Column capture
    logic [11:0] row_data; // Row capture
    logic [11:0] dir_data; // Direct capture
    int n_errors; // Mismatches
    int cmp_count; // Comparisons
    io_element_block io_element_block_i (.CLK_IN(clk), .ARST_N_IN(arst_n), .ROW_BLOCK_IN(row_blk),
        .BLK_CTRL_IN(blk_ctrl), .IO_CLK_IN(io_clk), .ELEM_LINES_IN(lines),
        .ARRAY_LINES_IN(arr_lines), .ELEM_CFG_IN(cfg), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE_OUT(pin_oe), .COL_DATA_OUT(col_data), .ROW_DATA_OUT(row_data),
        .DIRECT_DATA_OUT(dir_data));
    fabric_model fabric_model_i (.clk_in(clk), .arst_n_in(arst_n), .io_clk_out(io_clk),
        .array_lines_out(arr_lines));
    // Clock
    always #25 clk = ~clk;
    // Compare and count
    task automatic check_val(input string name, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        row_blk = 1'b0;
        blk_ctrl = '0;
        lines = '0;
        pin_in = 6'h00;
        cfg = {6{BASE}};
        cfg[0].ceout_src = io_pkg::SRC_ELEM;
        cfg[0].oe_src = io_pkg::SRC_ELEM;
        cfg[1].ddr_out = 1'b1;
        cfg[1].clkout_src = io_pkg::SRC_IOCLK0;
        cfg[2].oe_src = io_pkg::SRC_ELEM;
        cfg[2].oe_reg_en = 1'b1;
        cfg[2].oe_neg_en = 1'b1;
        cfg[3].ddr_in = 1'b1;
        cfg[3].data_array = 1'b1; // Output data over the array path
        cfg[4].oe_src = io_pkg::SRC_ONE;
        cfg[5].aclr_src = io_pkg::SRC_BLK0;
        cfg[5].sclr_src = io_pkg::SRC_ELEM;
        cfg[5].sclr_set = 1'b1;
        repeat (10) @(posedge clk);
        check_val("reset_pins", 12'h000, {6'h00, pin_out});
        arst_n <= 1'b1;
        // Table of plain drive and direct enable cases
        foreach (rows[i]) begin
            @(posedge clk);
            lines[0].dout_a <= rows[i][4];
            lines[0].ce_out <= rows[i][3];
            lines[0].oe <= rows[i][2];
            @(posedge clk);
            @(negedge clk);
            check_val("pin0", {11'h000, rows[i][1]}, {11'h000, pin_out[0]});
            check_val("oe0", {11'h000, rows[i][0]}, {11'h000, pin_oe[0]});
        end
        // Double-rate drive, both bit orders
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            lines[1].dout_a <= !k[0];
            lines[1].dout_b <= k[0];
            @(posedge clk);
            #10;
            check_val("ddr_high", {11'h000, !k[0]}, {11'h000, pin_out[1]});
            @(negedge clk);
            #10;
            check_val("ddr_low", {11'h000, k[0]}, {11'h000, pin_out[1]});
        end
        // Falling-edge enable holds the driver off
        @(posedge clk);
        lines[2].oe <= 1'b1;
        @(posedge clk);
        #10;
        check_val("oe_neg_high", 12'h000, {11'h000, pin_oe[2]});
        @(negedge clk);
        #10;
        check_val("oe_neg_low", 12'h001, {11'h000, pin_oe[2]});
        // Async clear, then sync preset over a load
        @(posedge clk);
        lines[5].dout_a <= 1'b1;
        repeat (2) @(posedge clk);
        blk_ctrl.clr[0] <= 1'b1;
        #10;
        check_val("aclr", 12'h000, {11'h000, pin_out[5]});
        @(posedge clk);
        blk_ctrl.clr[0] <= 1'b0;
        lines[5].dout_a <= 1'b0;
        lines[5].clr <= 1'b1;
        #10;
        check_val("sclr_wait", 12'h000, {11'h000, pin_out[5]});
        @(posedge clk);
        lines[5].clr <= 1'b0;
        #10;
        check_val("sclr_edge", 12'h001, {11'h000, pin_out[5]});
        // Double-rate capture in column, then row shape
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            row_blk <= k[0];
            pin_in[3] <= !k[0];
            @(negedge clk);
            pin_in[3] <= k[0];
            repeat (2) @(posedge clk);
            @(negedge clk);
            check_val("cap_col", {10'h000, k[0], !k[0]}, {10'h000, col_data[7:6]});
            check_val("cap_row", {10'h000, k[0], 1'b0}, {10'h000, row_data[7:6]});
            check_val("cap_dir", {10'h000, k[0], 1'b0}, {10'h000, dir_data[7:6]});
            check_val("oe4", {11'h000, !k[0]}, {11'h000, pin_oe[4]});
            // Array lines toggle every cycle, so the pin shows the inverse
            check_val("arr_pin", {11'h000, !arr_lines[3].dout_a}, {11'h000, pin_out[3]});
        end
        // Reset in mid-run clears at once
        @(posedge clk);
        arst_n <= 1'b0;
        #10;
        check_val("rst_pins", 12'h000, {6'h00, pin_out});
        check_val("rst_cap", 12'h000, col_data);
        check_val("rst_dir", 12'h000, dir_data);
        check_val("rst_oe", 12'h000, {6'h00, pin_oe});
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        // Release edge loads nothing; elements 0 and 3 load on the next rise
        @(negedge clk);
        check_val("rel_edge0", 12'h000, {6'h00, pin_out});
        @(negedge clk);
        check_val("rel_edge1", {8'h00, !arr_lines[3].dout_a, 3'h1}, {6'h00, pin_out});
        wrap_up();
    end
endmodule // tb_io_element_block
